//--- hdl/acgdc_regs.sv
`timescale 1ns/1ps
// What this block does
// - word read pops one whole result
// - default output is offset binary
// - offset binary bipolar zero reads 8000
// - two's complement: 8000 low, 7FFF high
// - format 01 twos, 00 offset, not unipolar
// - offset 4 holds channels 0-7 gain codes
// - gain codes mean x1, x2, x5, x10
// - offset 6 holds channels 8-15 gain codes
// - new channel applies its stored gain code
// - dac 1 at 8, dac 0 at E
// - dacs take 12-bit values
// - power-up in automatic mode, immediate update
// - simultaneous mode holds until update
// - D000 selects simultaneous mode
// - E000 selects automatic mode
// - 8000 moves held values to outputs
// - F000 zeroes both dac outputs
// - external scan start when enabled
// - external conversion trigger when enabled
// - counter 0 and 2 outputs brought out
// - board-reset read clears controls, dacs zero
module acgdc_regs
  import acgdc_pkg::*;
#(
  parameter int SAMPLE_W   = 16,
  parameter int DAC_W      = 12,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_n_i,
  input  wire logic [4:0]          host_addr_i,
  input  wire logic                host_word_i,
  input  wire logic                host_wr_i,
  input  wire logic                host_rd_i,
  input  wire logic [15:0]         host_wdata_i,
  output logic      [15:0]         host_rdata_o,
  output logic                     host_rvalid_o,
  input  wire logic [SAMPLE_W-1:0] adc_sample_i,
  input  wire logic                adc_sample_valid_i,
  input  wire logic [3:0]          adc_channel_i,
  input  wire logic                bipolar_jumper_i,
  input  wire logic                external_scan_start_input_i,
  input  wire logic                external_conversion_trigger_input_i,
  input  wire logic                counter0_out_i,
  input  wire logic                counter2_out_i,
  output logic      [1:0]          amp_gain_code_o,
  output logic      [3:0]          amp_gain_factor_o,
  output logic      [DAC_W-1:0]    dac_zero_o,
  output logic      [DAC_W-1:0]    dac_one_o,
  output logic                     dac_simul_mode_o,
  output logic                     scan_start_o,
  output logic                     conv_trigger_o,
  output logic                     counter0_pin_o,
  output logic                     counter2_pin_o,
  output logic                     adc_pause_o
);

  // access decode
  logic            word_wr;            // word-space write
  logic            byte_wr;            // byte-space write
  logic            fifo_rd;            // word read of the result fifo
  logic            board_rst;          // byte read of the reset location
  logic            dac_wr;             // word write to either dac

  // result fifo wiring
  logic [SAMPLE_W-1:0] fifo_head;      // oldest sample, offset binary
  logic            fifo_empty;         // nothing to read
  logic            fifo_full;          // converter must pause

  // control registers
  logic [15:0]     gain_lo_reg;        // channels 0-7 codes
  logic [15:0]     gain_lo_next;
  logic [15:0]     gain_hi_reg;        // channels 8-15 codes
  logic [15:0]     gain_hi_next;
  logic            twos_reg;           // two's complement output
  logic            twos_next;
  logic [1:0]      trig_sel_reg;       // external trigger enables
  logic [1:0]      trig_sel_next;

  // dac state
  acgdc_dac_mode_t mode_reg;           // automatic or simultaneous
  acgdc_dac_mode_t mode_next;
  logic [DAC_W-1:0] hold0_reg;         // written, not yet shown
  logic [DAC_W-1:0] hold0_next;
  logic [DAC_W-1:0] hold1_reg;
  logic [DAC_W-1:0] hold1_next;
  logic [DAC_W-1:0] dac0_reg;          // values on the converters
  logic [DAC_W-1:0] dac0_next;
  logic [DAC_W-1:0] dac1_reg;
  logic [DAC_W-1:0] dac1_next;

  // read port
  logic [15:0]     rdata_reg;
  logic [15:0]     rdata_next;
  logic            rvalid_reg;
  logic            rvalid_next;

  // gain application
  logic [3:0]      chan_prev_reg;      // channel seen last cycle
  logic            gain_armed_reg;     // first cycle after reset
  logic [1:0]      gain_code_reg;
  logic [1:0]      gain_code_next;
  logic [3:0]      gain_fact_reg;
  logic [3:0]      gain_fact_next;

  // pin synchronisers: jumper, scan start, conversion trigger
  logic [2:0]      pin_meta_reg;       // first stage, read by stage two
  logic [2:0]      pin_sync_reg;       // safe level
  logic [2:0]      pin_prev_reg;       // for edge detection
  logic            scan_reg;
  logic            scan_next;
  logic            conv_reg;
  logic            conv_next;
  logic            cnt0_reg;
  logic            cnt2_reg;
  logic            pause_reg;
  logic            bipolar;

  assign word_wr   = host_wr_i & host_word_i;
  assign byte_wr   = host_wr_i & ~host_word_i;
  assign fifo_rd   = host_rd_i & host_word_i &
                     (host_addr_i == OFS_RESULT_FIFO);
  assign board_rst = host_rd_i & ~host_word_i &
                     (host_addr_i == OFS_BOARD_RESET);
  assign dac_wr    = word_wr & ((host_addr_i == OFS_DAC_ONE) |
                                (host_addr_i == OFS_DAC_ZERO));
  assign bipolar   = pin_sync_reg[0];

  // result storage; a read takes one whole entry
  acgdc_result_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .push_i      (adc_sample_valid_i),
    .push_data_i (adc_sample_i),
    .pop_i       (fifo_rd),
    .head_o      (fifo_head),
    .empty_o     (fifo_empty),
    .full_o      (fifo_full)
  );

  // control register writes; board reset clears them all
  always_comb begin
    gain_lo_next  = gain_lo_reg;
    gain_hi_next  = gain_hi_reg;
    twos_next     = twos_reg;
    trig_sel_next = trig_sel_reg;
    if (board_rst) begin
      // fifo contents are left alone
      gain_lo_next  = RST_GAIN;
      gain_hi_next  = RST_GAIN;
      twos_next     = 1'b0;
      trig_sel_next = RST_TRIG;
    end else if (word_wr) begin
      if (host_addr_i == OFS_GAIN_LOW) begin
        gain_lo_next = host_wdata_i;
      end
      if (host_addr_i == OFS_GAIN_HIGH) begin
        gain_hi_next = host_wdata_i;
      end
    end else if (byte_wr) begin
      if (host_addr_i == OFS_FORMAT_SEL) begin
        // two's complement only accepted on a bipolar range
        if (host_wdata_i[7:0] == FMT_TWOS && bipolar) begin
          twos_next = 1'b1;
        end else if (host_wdata_i[7:0] == FMT_OFFSET) begin
          twos_next = 1'b0;
        end
      end
      if (host_addr_i == OFS_EXT_TRIG_SEL) begin
        trig_sel_next = host_wdata_i[1:0];
      end
    end
  end

  // control registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gain_lo_reg  <= RST_GAIN;
      gain_hi_reg  <= RST_GAIN;
      twos_reg     <= 1'b0;
      trig_sel_reg <= RST_TRIG;
    end else begin
      gain_lo_reg  <= gain_lo_next;
      gain_hi_reg  <= gain_hi_next;
      twos_reg     <= twos_next;
      trig_sel_reg <= trig_sel_next;
    end
  end

  // dac data and mode commands
  always_comb begin
    mode_next  = mode_reg;
    hold0_next = hold0_reg;
    hold1_next = hold1_reg;
    dac0_next  = dac0_reg;
    dac1_next  = dac1_reg;
    if (board_rst) begin
      mode_next  = ACGDC_DAC_AUTO;
      hold0_next = RST_DAC;
      hold1_next = RST_DAC;
      dac0_next  = RST_DAC;
      dac1_next  = RST_DAC;
    end else if (dac_wr) begin
      if (host_wdata_i[15:12] == DAC_DATA_NIBBLE) begin
        // plain data; relies on the host keeping the nibble clear
        if (host_addr_i == OFS_DAC_ZERO) begin
          hold0_next = host_wdata_i[DAC_W-1:0];
          if (mode_reg == ACGDC_DAC_AUTO) begin
            dac0_next = host_wdata_i[DAC_W-1:0];
          end
        end else begin
          hold1_next = host_wdata_i[DAC_W-1:0];
          if (mode_reg == ACGDC_DAC_AUTO) begin
            dac1_next = host_wdata_i[DAC_W-1:0];
          end
        end
      end else begin
        // command words must match exactly
        case (host_wdata_i)
          DAC_CMD_SIMUL: begin
            mode_next = ACGDC_DAC_SIMUL;
          end
          DAC_CMD_AUTO: begin
            mode_next = ACGDC_DAC_AUTO;
          end
          DAC_CMD_UPDATE: begin
            dac0_next = hold0_reg;
            dac1_next = hold1_reg;
          end
          DAC_CMD_ZERO: begin
            hold0_next = RST_DAC;
            hold1_next = RST_DAC;
            dac0_next  = RST_DAC;
            dac1_next  = RST_DAC;
          end
          default: begin
            mode_next = mode_reg;
          end
        endcase
      end
    end
  end

  // dac registers; outputs start at zero in automatic mode
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode_reg  <= ACGDC_DAC_AUTO;
      hold0_reg <= RST_DAC;
      hold1_reg <= RST_DAC;
      dac0_reg  <= RST_DAC;
      dac1_reg  <= RST_DAC;
    end else begin
      mode_reg  <= mode_next;
      hold0_reg <= hold0_next;
      hold1_reg <= hold1_next;
      dac0_reg  <= dac0_next;
      dac1_reg  <= dac1_next;
    end
  end

  // result read; flipping the top bit turns offset binary into signed
  always_comb begin
    rvalid_next = host_rd_i;
    rdata_next  = RST_RDATA;
    if (fifo_rd && !fifo_empty) begin
      rdata_next = fifo_head;
      if (twos_reg && bipolar) begin
        rdata_next = {~fifo_head[SAMPLE_W-1],
                      fifo_head[SAMPLE_W-2:0]};
      end
    end
  end

  // read data register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_reg  <= RST_RDATA;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // gain lookup for the channel being converted
  always_comb begin
    gain_code_next = gain_code_reg;
    gain_fact_next = gain_fact_reg;
    if (gain_armed_reg || adc_channel_i != chan_prev_reg) begin
      if (adc_channel_i[3]) begin
        gain_code_next = acgdc_gain_field(gain_hi_reg,
                                          adc_channel_i[2:0]);
      end else begin
        gain_code_next = acgdc_gain_field(gain_lo_reg,
                                          adc_channel_i[2:0]);
      end
      gain_fact_next = acgdc_gain_factor(gain_code_next);
    end
  end

  // gain registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      chan_prev_reg  <= 4'h0;
      gain_armed_reg <= 1'b1;
      gain_code_reg  <= 2'b00;
      gain_fact_reg  <= GAIN_X1;
    end else begin
      chan_prev_reg  <= adc_channel_i;
      gain_armed_reg <= 1'b0;
      gain_code_reg  <= gain_code_next;
      gain_fact_reg  <= gain_fact_next;
    end
  end

  // rising edges of the external pins, gated by the trigger select
  always_comb begin
    conv_next = trig_sel_reg[TRIG_BIT_CONV] &
                pin_sync_reg[2] & ~pin_prev_reg[2];
    scan_next = trig_sel_reg[TRIG_BIT_SCAN] &
                pin_sync_reg[1] & ~pin_prev_reg[1];
  end

  // pin synchronisers and pin-facing outputs
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= 3'b000;
      pin_sync_reg <= 3'b000;
      pin_prev_reg <= 3'b000;
      scan_reg     <= 1'b0;
      conv_reg     <= 1'b0;
      cnt0_reg     <= 1'b0;
      cnt2_reg     <= 1'b0;
      pause_reg    <= 1'b0;
    end else begin
      pin_meta_reg <= {external_conversion_trigger_input_i,
                       external_scan_start_input_i,
                       bipolar_jumper_i};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      scan_reg     <= scan_next;
      conv_reg     <= conv_next;
      cnt0_reg     <= counter0_out_i;
      cnt2_reg     <= counter2_out_i;
      pause_reg    <= fifo_full;
    end
  end

  assign host_rdata_o      = rdata_reg;
  assign host_rvalid_o     = rvalid_reg;
  assign amp_gain_code_o   = gain_code_reg;
  assign amp_gain_factor_o = gain_fact_reg;
  assign dac_zero_o        = dac0_reg;
  assign dac_one_o         = dac1_reg;
  assign dac_simul_mode_o  = mode_reg[1];
  assign scan_start_o      = scan_reg;
  assign conv_trigger_o    = conv_reg;
  assign counter0_pin_o    = cnt0_reg;
  assign counter2_pin_o    = cnt2_reg;
  assign adc_pause_o       = pause_reg;

endmodule

//--- hdl/acgdc_result_fifo.sv
`timescale 1ns/1ps
// conversion result fifo; head word is visible while not empty
module acgdc_result_fifo
  import acgdc_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] head_o,
  output logic                  empty_o,
  output logic                  full_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];      // sample storage
  logic [AW-1:0]    wr_ptr_reg;       // next slot to fill
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;       // oldest sample
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_reg;        // samples held
  logic [AW:0]      count_next;
  logic             do_push;
  logic             do_pop;

  assign empty_o = (count_reg == '0);
  assign full_o  = (count_reg == (AW+1)'(DEPTH));
  assign head_o  = mem[rd_ptr_reg];

  // pointer and count bookkeeping; a push into a full fifo is dropped
  always_comb begin
    do_push     = push_i & ~full_o;
    do_pop      = pop_i & ~empty_o;
    wr_ptr_next = do_push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
    rd_ptr_next = do_pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
    count_next  = count_reg;
    if (do_push & ~do_pop) begin
      count_next = (AW+1)'(count_reg + 1'b1);
    end else if (do_pop & ~do_push) begin
      count_next = (AW+1)'(count_reg - 1'b1);
    end
  end

  // pointer registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // storage write, no reset on the array
  always_ff @(posedge clk_sys_i) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data_i;
    end
  end

endmodule

//--- include/acgdc_pkg.sv
// shared constants for the converter, gain and dac control block
package acgdc_pkg;

  // word-space register offsets (byte offsets from the word base)
  localparam logic [4:0] OFS_RESULT_FIFO  = 5'h00;
  localparam logic [4:0] OFS_GAIN_LOW     = 5'h04;
  localparam logic [4:0] OFS_GAIN_HIGH    = 5'h06;
  localparam logic [4:0] OFS_DAC_ONE      = 5'h08;
  localparam logic [4:0] OFS_DAC_ZERO     = 5'h0e;

  // byte-space register offsets (from the byte base)
  localparam logic [4:0] OFS_FORMAT_SEL   = 5'h0d;
  localparam logic [4:0] OFS_EXT_TRIG_SEL = 5'h1c;
  localparam logic [4:0] OFS_BOARD_RESET  = 5'h1d;

  // format select byte values
  localparam logic [7:0] FMT_TWOS         = 8'h01;
  localparam logic [7:0] FMT_OFFSET       = 8'h00;

  // external trigger select field positions
  localparam int         TRIG_BIT_CONV    = 0;
  localparam int         TRIG_BIT_SCAN    = 1;

  // dac control words written to either dac register
  localparam logic [15:0] DAC_CMD_SIMUL   = 16'hd000;
  localparam logic [15:0] DAC_CMD_AUTO    = 16'he000;
  localparam logic [15:0] DAC_CMD_UPDATE  = 16'h8000;
  localparam logic [15:0] DAC_CMD_ZERO    = 16'hf000;
  localparam logic [3:0]  DAC_DATA_NIBBLE = 4'h0;

  // values after reset and after a board-reset read
  localparam logic [15:0] RST_GAIN        = 16'h0000;
  localparam logic [11:0] RST_DAC         = 12'h000;
  localparam logic [1:0]  RST_TRIG        = 2'b00;
  localparam logic [15:0] RST_RDATA       = 16'h0000;

  // amplifier gain factors per 2-bit code
  localparam logic [3:0] GAIN_X1          = 4'h1;
  localparam logic [3:0] GAIN_X2          = 4'h2;
  localparam logic [3:0] GAIN_X5          = 4'h5;
  localparam logic [3:0] GAIN_X10         = 4'ha;

  // result fifo depth in samples
  localparam int         FIFO_DEPTH_DEF   = 1024;

  // dac update mode, one-hot
  typedef enum logic [1:0] {
    ACGDC_DAC_AUTO  = 2'b01,
    ACGDC_DAC_SIMUL = 2'b10
  } acgdc_dac_mode_t;

  // decode a 2-bit gain code into the amplifier factor
  function automatic logic [3:0] acgdc_gain_factor(input logic [1:0] code);
    case (code)
      2'd0:    acgdc_gain_factor = GAIN_X1;
      2'd1:    acgdc_gain_factor = GAIN_X2;
      2'd2:    acgdc_gain_factor = GAIN_X5;
      default: acgdc_gain_factor = GAIN_X10;
    endcase
  endfunction

  // pick channel n's code out of a packed 8-channel gain word
  function automatic logic [1:0] acgdc_gain_field(input logic [15:0] word,
                                                  input logic [2:0]  idx);
    acgdc_gain_field = word[{idx, 1'b0} +: 2];
  endfunction

endpackage

//--- verif/acgdc_host_model.sv
`timescale 1ns/1ps
// host model: one-cycle strobed accesses
module acgdc_host_model
  import acgdc_pkg::*;
(
  input  wire logic   clk_sys_i,
  output logic [4:0]  host_addr_o,
  output logic        host_word_o,
  output logic        host_wr_o,
  output logic        host_rd_o,
  output logic [15:0] host_wdata_o
);
  // idle bus at time zero
  initial begin
    {host_word_o, host_wr_o, host_rd_o} = 3'b000;
    {host_addr_o, host_wdata_o} = {5'h1f, 16'h5a5a};
  end

  // one access; afterwards the bus shows the inverse
  task automatic access(input logic wr, input logic word,
                        input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    host_wr_o    <= wr;
    host_rd_o    <= !wr;
    host_word_o  <= word;
    host_addr_o  <= a;
    host_wdata_o <= d;
    @(posedge clk_sys_i);
    host_wr_o    <= 1'b0;
    host_rd_o    <= 1'b0;
    host_addr_o  <= ~a;
    host_wdata_o <= ~d;
  endtask

  // dac value write keeps the top nibble clear
  task automatic dac_value(input logic [4:0] a, input logic [11:0] v);
    access(1'b1, 1'b1, a, {DAC_DATA_NIBBLE, v});
  endtask
endmodule

//--- verif/acgdc_regs_asserts.sv
`timescale 1ns/1ps
// checks host answers, dac, gain and pin outputs
module acgdc_regs_chk
  import acgdc_pkg::*;
#(
  parameter int DAC_W = 12
) (
  input wire logic             clk_sys_i,
  input wire logic             rst_n_i,
  input wire logic [4:0]       host_addr_i,
  input wire logic             host_word_i,
  input wire logic             host_wr_i,
  input wire logic             host_rd_i,
  input wire logic [15:0]      host_wdata_i,
  input wire logic             host_rvalid_o,
  input wire logic             counter0_out_i,
  input wire logic             counter2_out_i,
  input wire logic [1:0]       amp_gain_code_o,
  input wire logic [3:0]       amp_gain_factor_o,
  input wire logic [DAC_W-1:0] dac_zero_o,
  input wire logic [DAC_W-1:0] dac_one_o,
  input wire logic             dac_simul_mode_o,
  input wire logic             scan_start_o,
  input wire logic             conv_trigger_o,
  input wire logic             counter0_pin_o,
  input wire logic             counter2_pin_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // any word write to either dac register
  logic wr_dac;
  // data write: top nibble clear
  logic wr_data;
  assign wr_dac  = host_wr_i && host_word_i &&
                   (host_addr_i == OFS_DAC_ZERO || host_addr_i == OFS_DAC_ONE);
  assign wr_data = wr_dac && host_wdata_i[15:12] == DAC_DATA_NIBBLE;

  a_read_answer: assert property (host_rd_i |=> host_rvalid_o)
    else $error("read strobe got no answer");
  a_no_stray_answer: assert property (!host_rd_i |=> !host_rvalid_o)
    else $error("answer without read");
  a_auto_zero_write: assert property (
    wr_data && host_addr_i == OFS_DAC_ZERO && !dac_simul_mode_o
    |=> dac_zero_o == $past(host_wdata_i[DAC_W-1:0]))
    else $error("dac zero not updated on write");
  a_auto_one_write: assert property (
    wr_data && host_addr_i == OFS_DAC_ONE && !dac_simul_mode_o
    |=> dac_one_o == $past(host_wdata_i[DAC_W-1:0]))
    else $error("dac one not updated on write");
  a_simul_hold: assert property (
    wr_data && dac_simul_mode_o |=> $stable(dac_zero_o) && $stable(dac_one_o))
    else $error("dac output moved in simultaneous mode");
  a_simul_enter: assert property (
    wr_dac && host_wdata_i == DAC_CMD_SIMUL |=> dac_simul_mode_o)
    else $error("simultaneous mode not entered");
  a_auto_enter: assert property (
    wr_dac && host_wdata_i == DAC_CMD_AUTO |=> !dac_simul_mode_o)
    else $error("automatic mode not entered");
  a_zero_cmd: assert property (
    wr_dac && host_wdata_i == DAC_CMD_ZERO
    |=> dac_zero_o == '0 && dac_one_o == '0)
    else $error("dac outputs not zeroed");
  a_board_reset: assert property (
    host_rd_i && !host_word_i && host_addr_i == OFS_BOARD_RESET
    |=> dac_zero_o == '0 && dac_one_o == '0 && !dac_simul_mode_o)
    else $error("board reset left dac state");
  a_gain_factor: assert property (
    amp_gain_factor_o == (amp_gain_code_o[1] ?
      (amp_gain_code_o[0] ? GAIN_X10 : GAIN_X5) :
      (amp_gain_code_o[0] ? GAIN_X2 : GAIN_X1)))
    else $error("gain factor does not match code");
  a_scan_pulse: assert property (scan_start_o |=> !scan_start_o)
    else $error("scan start pulse too long");
  a_conv_pulse: assert property (conv_trigger_o |=> !conv_trigger_o)
    else $error("conversion trigger pulse too long");
  a_counter_copy: assert property ($past(rst_n_i) |->
    counter0_pin_o == $past(counter0_out_i) &&
    counter2_pin_o == $past(counter2_out_i))
    else $error("counter pin copy wrong");
endmodule

bind acgdc_regs acgdc_regs_chk #(.DAC_W(DAC_W)) chk_u (.*);

//--- verif/tb_top.sv
`timescale 1ns/1ps
// bench for the converter, gain and dac register block
module tb_top;
  import acgdc_pkg::*;
  localparam int LIMIT = 20000; // cycle ceiling for a hung run
  logic        clk_sys_i, rst_n_i;
  logic [4:0]  host_addr_i;
  logic        host_word_i, host_wr_i, host_rd_i;
  logic [15:0] host_wdata_i, host_rdata_o, adc_sample_i;
  logic        host_rvalid_o, adc_sample_valid_i, bipolar_jumper_i;
  logic [3:0]  adc_channel_i, amp_gain_factor_o;
  logic [1:0]  pins_drv; // scan start, conversion trigger
  logic        counter0_out_i, counter2_out_i, dac_simul_mode_o;
  logic [1:0]  amp_gain_code_o, code;
  logic [11:0] dac_zero_o, dac_one_o;
  logic        scan_start_o, conv_trigger_o, counter0_pin_o, counter2_pin_o;
  logic [15:0] seed = 16'h74ec; // lfsr state, 29932
  logic [15:0] v, w, lo, hi, g;
  logic [3:0]  ch;
  logic [3:0]  fac [4] = '{4'h1, 4'h2, 4'h5, 4'ha}; // factor per code
  logic [15:0] q [$]; // expected read data, oldest first
  int          checks, n_mismatch, cycle, n_conv, n_scan;

  acgdc_host_model host_u (.clk_sys_i, .host_addr_o(host_addr_i),
    .host_word_o(host_word_i), .host_wr_o(host_wr_i),
    .host_rd_o(host_rd_i), .host_wdata_o(host_wdata_i));
  acgdc_regs #(.FIFO_DEPTH(8)) dut_u (.*, .adc_pause_o(),
    .external_scan_start_input_i(pins_drv[1]),
    .external_conversion_trigger_input_i(pins_drv[0]));

  // 250 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // compare one value, count and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // next pseudo-random word
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  // wait edges, then step past the edge's updates
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic word, input logic [4:0] a,
                    input logic [15:0] d);
    host_u.access(1'b1, word, a, d);
    #1;
  endtask

  // read; the watcher compares the answer
  task automatic rd(input logic word, input logic [4:0] a,
                    input logic [15:0] exp);
    q.push_back(exp);
    host_u.access(1'b0, word, a, 16'h0000);
  endtask

  // push one converter sample
  task automatic ps(input logic [15:0] s);
    @(posedge clk_sys_i);
    adc_sample_i       <= s;
    adc_sample_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    adc_sample_valid_i <= 1'b0;
  endtask

  // push one sample, then read it back
  task automatic pr(input logic [15:0] s, input logic [15:0] exp);
    ps(s);
    rd(1'b1, OFS_RESULT_FIFO, exp);
  endtask

  // trigger pins high 6 cycles, then low 8
  task automatic pins();
    @(posedge clk_sys_i);
    pins_drv <= 2'b11;
    repeat (6) @(posedge clk_sys_i);
    pins_drv <= 2'b00;
    cyc(8);
  endtask

  // watcher: read answers, pin pulses, counter pins, hang limit
  always @(posedge clk_sys_i) begin
    cycle++;
    counter0_out_i <= cycle[2];
    counter2_out_i <= cycle[3];
    if (host_rvalid_o === 1'b1) begin
      if (q.size() == 0) chk(1'b1, 1'b0);
      else chk(host_rdata_o, q.pop_front());
    end
    if (conv_trigger_o === 1'b1) n_conv++;
    if (scan_start_o === 1'b1) n_scan++;
    if (cycle == LIMIT) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    rst_n_i = 1'b0;
    {adc_sample_i, adc_sample_valid_i, adc_channel_i, bipolar_jumper_i,
     pins_drv} = '0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    cyc(3);
    chk(dac_simul_mode_o, 1'b0);
    // automatic mode: values land at once, full scale on dac one
    v = rnd();
    host_u.dac_value(OFS_DAC_ZERO, v[11:0]);
    #1 chk(dac_zero_o, v[11:0]);
    host_u.dac_value(OFS_DAC_ONE, 12'hfff);
    #1 chk(dac_one_o, 12'hfff);
    // near-miss command words change nothing
    wr(1'b1, OFS_DAC_ZERO, 16'h9000);
    wr(1'b1, OFS_DAC_ONE, 16'hd001);
    chk(dac_zero_o, v[11:0]);
    chk(dac_simul_mode_o, 1'b0);
    // simultaneous mode holds writes until the update word
    wr(1'b1, OFS_DAC_ONE, DAC_CMD_SIMUL);
    chk(dac_simul_mode_o, 1'b1);
    w = rnd();
    host_u.dac_value(OFS_DAC_ZERO, w[11:0]);
    host_u.dac_value(OFS_DAC_ONE, w[15:4]);
    #1 chk(dac_zero_o, v[11:0]);
    chk(dac_one_o, 12'hfff);
    wr(1'b1, OFS_DAC_ZERO, DAC_CMD_UPDATE);
    chk(dac_zero_o, w[11:0]);
    chk(dac_one_o, w[15:4]);
    wr(1'b1, OFS_DAC_ONE, DAC_CMD_ZERO);
    chk({dac_zero_o, dac_one_o}, 16'h0000);
    wr(1'b1, OFS_DAC_ZERO, DAC_CMD_AUTO);
    chk(dac_simul_mode_o, 1'b0);
    // gain codes: fixed all-codes pass, then random
    for (int p = 0; p < 2; p++) begin
      lo = p ? rnd() : 16'he4e4;
      hi = p ? rnd() : 16'h1b1b;
      wr(1'b1, OFS_GAIN_LOW, lo);
      wr(1'b1, OFS_GAIN_HIGH, hi);
      for (int i = 1; i <= 16; i++) begin
        ch = i[3:0];
        @(posedge clk_sys_i);
        adc_channel_i <= ch;
        cyc(3);
        g = ch[3] ? hi : lo;
        code = g[{ch[2:0], 1'b0} +: 2];
        chk(amp_gain_code_o, code);
        chk(amp_gain_factor_o, fac[code]);
      end
    end
    // result words and their formats
    v = rnd();
    pr(v, v);
    wr(1'b0, OFS_FORMAT_SEL, {8'h00, FMT_TWOS});
    pr(16'h8000, 16'h8000);
    @(posedge clk_sys_i);
    bipolar_jumper_i <= 1'b1;
    cyc(4);
    wr(1'b0, OFS_FORMAT_SEL, {8'h00, FMT_TWOS});
    pr(16'hffff, 16'h7fff);
    pr(16'h0000, 16'h8000);
    pr(16'h8000, 16'h0000);
    pr(16'h7fff, 16'hffff);
    wr(1'b0, OFS_FORMAT_SEL, {8'h00, FMT_OFFSET});
    pr(16'h8000, 16'h8000);
    rd(1'b1, OFS_RESULT_FIFO, 16'h0000);
    rd(1'b1, 5'h02, 16'h0000);
    // external triggers: disabled, then both enabled
    wr(1'b0, OFS_EXT_TRIG_SEL, 16'h0000);
    pins();
    chk(n_conv + n_scan, 0);
    wr(1'b0, OFS_EXT_TRIG_SEL, 16'h0003);
    pins();
    chk(n_conv, 1);
    chk(n_scan, 1);
    // board reset read keeps the fifo, clears the rest
    host_u.dac_value(OFS_DAC_ZERO, v[11:0]);
    wr(1'b1, OFS_DAC_ONE, DAC_CMD_SIMUL);
    w = rnd();
    ps(w);
    rd(1'b0, OFS_BOARD_RESET, 16'h0000);
    cyc(2);
    chk({dac_zero_o, dac_one_o, dac_simul_mode_o}, 0);
    rd(1'b1, OFS_RESULT_FIFO, w);
    @(posedge clk_sys_i);
    adc_channel_i <= 4'h5;
    cyc(3);
    chk(amp_gain_code_o, 2'd0);
    cyc(3);
    tally_and_finish();
  end
endmodule
